/* bus_seq_consts.svh */
// timing and register constants of the external bus cycle sequencer
`ifndef BUS_SEQ_CONSTS_SVH
`define BUS_SEQ_CONSTS_SVH
`define NUM_CS            4
`define TIMING_BASE       8'h00
`define CTRL_ADDR         8'h10
`define STATUS_ADDR       8'h14
`define AB_POS            0
`define AB_EXT_POS        1
`define C_POS             3
`define D_POS             5
`define E_POS             6
`define F_POS             11
`define RDY_EN_POS        13
`define TIMING_RESET      32'h0000_0000
`define UNIT_DIV_RESET    8'h01
`define ACCESS_MAX        6'h20
`endif

/* bus_seq_pkg.sv */
// types of the external bus cycle sequencer
package bus_seq_pkg;
  typedef enum logic [2:0] {
    PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_F
  } phase_e;
  typedef logic [1:0] cs_t;
endpackage

/* unit_divider.sv */
// bus time unit enable pulse generator
`timescale 1ns/1ps
module unit_divider (
  input  wire logic       clk,      // system clock
  input  wire logic       srst,     // sync reset
  input  wire logic       restart,  // realign unit boundary
  input  wire logic [7:0] div,      // clocks per unit, 0 acts as 1
  output logic            tick      // one-cycle unit pulse
);
  logic [7:0] cnt_q;
  logic [7:0] lim;
  assign lim  = (div == 8'h00) ? 8'h00 : div - 8'h01;
  assign tick = (cnt_q == lim) && !restart;
  always_ff @(posedge clk) begin
    if (srst || restart || tick) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* bus_cycle_sequencer.sv */
// external bus cycle sequencer with axi4-lite timing registers
// Function
// - each cycle runs address setup, command, data setup, access, hold
// - phase lengths come from per chip select timing registers
// - address setup lasts one or two bus time units
// - new address window adds zero to three units to address setup
// - write setup or tristate phase lasts zero or one unit
// - access lasts 1 to 32 units; ready may extend it
// - hold phase lasts zero to three units
// - read data captured on the edge ending the strobe
// - address held from request acceptance until the next request
`timescale 1ns/1ps
`include "bus_seq_consts.svh"
module bus_cycle_sequencer (
  input  wire logic                clk,           // 200 MHz clock
  input  wire logic                srst,          // sync reset
  input  wire logic [7:0]          s_awaddr,      // write address
  input  wire logic                s_awvalid,     // write address valid
  output logic                     s_awready,     // write address ready
  input  wire logic [31:0]         s_wdata,       // write data
  input  wire logic [3:0]          s_wstrb,       // write strobes
  input  wire logic                s_wvalid,      // write data valid
  output logic                     s_wready,      // write data ready
  output logic [1:0]               s_bresp,       // write response
  output logic                     s_bvalid,      // write response valid
  input  wire logic                s_bready,      // write response ready
  input  wire logic [7:0]          s_araddr,      // read address
  input  wire logic                s_arvalid,     // read address valid
  output logic                     s_arready,     // read address ready
  output logic [31:0]              s_rdata,       // read data
  output logic [1:0]               s_rresp,       // read response
  output logic                     s_rvalid,      // read data valid
  input  wire logic                s_rready,      // read data ready
  input  wire logic                req_valid,     // bus access request
  output logic                     req_ready,     // request taken
  input  wire logic                req_write,     // 1 write, 0 read
  input  wire bus_seq_pkg::cs_t    req_cs,        // chip select index
  input  wire logic [23:0]         req_addr,      // access address
  input  wire logic [15:0]         req_wdata,     // write data
  output logic                     done,          // access finished pulse
  output logic [15:0]              rd_data,       // captured read data
  output logic [23:0]              ext_addr,      // address pins
  output logic [3:0]               ext_cs_n,      // chip selects
  output logic                     ext_rd_n,      // read strobe
  output logic                     ext_wr_n,      // write strobe
  output logic [15:0]              ext_data_o,    // data out
  output logic                     ext_data_oe,   // data out enable
  input  wire logic [15:0]         ext_data_i,    // data in
  input  wire logic                ext_ready,     // ready handshake
  output bus_seq_pkg::phase_e      phase          // current phase
);
  import bus_seq_pkg::*;

  // register file
  logic [13:0] chip_select_timing_config_q [`NUM_CS];
  logic [7:0]  unit_div_q;
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] reg_read(input logic [7:0] a,
                                           input logic [31:0] st);
    reg_read = 32'h0000_0000;
    if (a < `TIMING_BASE + 8'h10 && a[1:0] == 2'b00) begin
      reg_read = {18'h0, chip_select_timing_config_q[a[3:2]]};
    end else if (a == `CTRL_ADDR) begin
      reg_read = {24'h0, unit_div_q};
    end else if (a == `STATUS_ADDR) begin
      reg_read = st;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) &&
             (a < `TIMING_BASE + 8'h10 || a == `CTRL_ADDR ||
              a == `STATUS_ADDR);
  endfunction

  wire do_write = aw_hold_q && w_hold_q && !s_bvalid;
  assign s_awready = !aw_hold_q && !s_bvalid;
  assign s_wready  = !w_hold_q && !s_bvalid;
  assign s_arready = !s_rvalid;

  logic        last_cs_valid_q;
  cs_t         last_cs_q;
  logic [31:0] status_w;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'b00;
      unit_div_q <= `UNIT_DIV_RESET;
      for (int i = 0; i < `NUM_CS; i++) begin
        chip_select_timing_config_q[i] <= 14'(`TIMING_RESET);
      end
    end else begin
      if (s_awvalid && s_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        s_bvalid  <= 1'b1;
        s_bresp   <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
        // timing settings per chip select
        if (aw_addr_q < `TIMING_BASE + 8'h10 && aw_addr_q[1:0] == 2'b00) begin
          if (w_strb_q[0]) begin
            chip_select_timing_config_q[aw_addr_q[3:2]][7:0] <=
              w_data_q[7:0];
          end
          if (w_strb_q[1]) begin
            chip_select_timing_config_q[aw_addr_q[3:2]][13:8] <=
              w_data_q[13:8];
          end
        end else if (aw_addr_q == `CTRL_ADDR && w_strb_q[0]) begin
          unit_div_q <= w_data_q[7:0];
        end
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= 2'b00;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= reg_read(s_araddr, status_w);
      s_rresp  <= mapped(s_araddr) ? 2'b00 : 2'b10;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // sequencer
  phase_e      ph_q;
  logic [5:0]  cnt_q;
  logic        wr_q;
  cs_t         cs_q;
  logic [13:0] tim_q;
  logic [15:0] wdata_q;
  logic        tick;
  logic        restart;

  unit_divider unit_divider_inst (
    .clk     (clk),
    .srst    (srst),
    .restart (restart),
    .div     (unit_div_q),
    .tick    (tick)
  );

  wire take = (ph_q == PH_IDLE) && req_valid;
  assign req_ready = (ph_q == PH_IDLE);
  assign restart   = take;
  assign phase     = ph_q;
  assign status_w  = {26'h0, last_cs_q, last_cs_valid_q, 3'(ph_q)};

  wire [13:0] tim_n = chip_select_timing_config_q[req_cs];
  // base setup 1 or 2 units plus window change extra
  wire        win_change = !last_cs_valid_q || (last_cs_q != req_cs);
  wire [5:0]  ab_len = {5'h0, 1'b1} + {5'h0, tim_n[`AB_POS]} +
                       (win_change ? {4'h0, tim_n[`AB_EXT_POS +: 2]} : 6'h00);
  wire [1:0]  c_len  = tim_q[`C_POS +: 2];
  wire        d_len  = tim_q[`D_POS];
  // access 1..32 units
  wire [5:0]  e_len  = {1'b0, tim_q[`E_POS +: 5]} + 6'h01;
  wire [1:0]  f_len  = tim_q[`F_POS +: 2];
  wire        rdy_en = tim_q[`RDY_EN_POS];
  wire        last_unit = tick && (cnt_q == 6'h01);
  // extend access while ready low after minimum length
  wire        e_end = last_unit && (!rdy_en || ext_ready);
  // next phase after command delay or a zero command delay, skipping a zero data setup
  wire phase_e after_c = d_len ? PH_D : PH_E;
  // phase entries and cycle end, so the pins follow the phase on one edge
  wire pre_data = (ph_q == PH_C) || (ph_q == PH_AB && c_len == 2'b00);
  wire enter_d  = last_unit && pre_data && d_len;
  wire enter_e  = last_unit && ((pre_data && !d_len) || ph_q == PH_D);
  wire to_idle  = (ph_q == PH_E && e_end && f_len == 2'b00) ||
                  (ph_q == PH_F && last_unit);

  always_ff @(posedge clk) begin
    if (srst) begin
      ph_q    <= PH_IDLE;
      cnt_q   <= 6'h00;
      wr_q    <= 1'b0;
      cs_q    <= 2'b00;
      tim_q   <= 14'h0000;
      wdata_q <= 16'h0000;
      ext_addr <= 24'h000000;
      last_cs_valid_q <= 1'b0;
      last_cs_q <= 2'b00;
    end else begin
      unique case (ph_q)
        PH_IDLE: if (take) begin
          ph_q    <= PH_AB;
          cnt_q   <= ab_len;
          wr_q    <= req_write;
          cs_q    <= req_cs;
          tim_q   <= tim_n;
          wdata_q <= req_wdata;
          ext_addr <= req_addr;
          last_cs_valid_q <= 1'b1;
          last_cs_q <= req_cs;
        end
        PH_AB: if (last_unit) begin
          if (c_len != 2'b00) begin
            ph_q  <= PH_C;
            cnt_q <= {4'h0, c_len};
          end else begin
            ph_q  <= after_c;
            cnt_q <= d_len ? 6'h01 : e_len;
          end
        end else if (tick) begin
          cnt_q <= cnt_q - 6'h01;
        end
        PH_C: if (last_unit) begin
          ph_q  <= after_c;
          cnt_q <= d_len ? 6'h01 : e_len;
        end else if (tick) begin
          cnt_q <= cnt_q - 6'h01;
        end
        PH_D: if (last_unit) begin
          ph_q  <= PH_E;
          cnt_q <= e_len;
        end else if (tick) begin
          cnt_q <= cnt_q - 6'h01;
        end
        PH_E: if (e_end) begin
          ph_q  <= (f_len != 2'b00) ? PH_F : PH_IDLE;
          cnt_q <= {4'h0, f_len};
        end else if (tick && cnt_q > 6'h01) begin
          cnt_q <= cnt_q - 6'h01;
        end
        PH_F: if (last_unit) begin
          ph_q <= PH_IDLE;
        end else if (tick) begin
          cnt_q <= cnt_q - 6'h01;
        end
      endcase
    end
  end

  // read data latched on the edge that raises the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
      done    <= 1'b0;
    end else begin
      done <= to_idle;
      if (ph_q == PH_E && e_end && !wr_q) begin
        rd_data <= ext_data_i;
      end
    end
  end

  wire active    = (ph_q != PH_IDLE);
  wire cs_on     = take || (active && !to_idle);
  wire cs_t cs_sel = take ? req_cs : cs_q;
  // strobe low for every clock of the access phase, even a one-clock one
  wire strobe_on = enter_e || (ph_q == PH_E && !e_end);
  wire in_data   = (ph_q == PH_D) || (ph_q == PH_E) || (ph_q == PH_F);
  wire drive_on  = (in_data && !to_idle) || enter_d || enter_e;
  // strobes asserted in access phase only
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_cs_n    <= 4'hF;
      ext_rd_n    <= 1'b1;
      ext_wr_n    <= 1'b1;
      ext_data_o  <= 16'h0000;
      ext_data_oe <= 1'b0;
    end else begin
      ext_cs_n    <= cs_on ? ~(4'h1 << cs_sel) : 4'hF;
      ext_rd_n    <= !(strobe_on && !wr_q);
      ext_wr_n    <= !(strobe_on && wr_q);
      ext_data_o  <= wdata_q;
      ext_data_oe <= wr_q && drive_on;
    end
  end
endmodule

/* bus_seq_asserts.sv */
// concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
module bus_seq_asserts (
  input wire logic                clk,        // clock
  input wire logic                srst,       // sync reset
  input wire logic                s_arvalid,  // read address valid
  input wire logic                s_arready,  // read address ready
  input wire logic                s_rvalid,   // read data valid
  input wire logic                s_bvalid,   // write response valid
  input wire logic                s_bready,   // write response ready
  input wire logic                req_ready,  // request taken
  input wire logic                done,       // access finished
  input wire logic [15:0]         rd_data,    // captured read data
  input wire logic                ext_rd_n,   // read strobe
  input wire logic                ext_wr_n,   // write strobe
  input wire logic [3:0]          ext_cs_n,   // chip selects
  input wire logic [15:0]         ext_data_i, // data in
  input wire bus_seq_pkg::phase_e phase       // current phase
);
  import bus_seq_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  phase_order_a: assert property ($past(phase) != PH_IDLE &&
    phase != $past(phase) |-> phase > $past(phase) || phase == PH_IDLE)
    else $error("phase order broken");
  idle_entry_a: assert property ($past(phase) == PH_IDLE &&
    phase != PH_IDLE |-> phase == PH_AB) else $error("cycle skips setup");
  idle_ready_a: assert property (phase == PH_IDLE |-> req_ready)
    else $error("idle but request refused");
  rd_window_a: assert property (!ext_rd_n |-> phase == PH_E)
    else $error("read strobe outside access");
  rd_capture_a: assert property ($rose(ext_rd_n) |->
    rd_data == $past(ext_data_i)) else $error("read data not captured");
  done_pulse_a: assert property (done |=> !done) else $error("done too long");
  strobe_excl_a: assert property (ext_rd_n || ext_wr_n)
    else $error("both strobes low");
  cs_active_a: assert property (!ext_rd_n || !ext_wr_n |->
    $onehot(~ext_cs_n)) else $error("strobe without one chip select");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped");
  rresp_time_a: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read response late");
  cover property ($rose(ext_rd_n));
  cover property (phase == PH_D);
  cover property (done);
  cover property (!ext_wr_n);
endmodule
bind bus_cycle_sequencer bus_seq_asserts bus_seq_asserts_inst (.*);

/* ext_mem_model.sv */
// behavioural external memory with ready handshake
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic        clk,         // clock
  input  wire logic        srst,        // sync reset
  input  wire logic [23:0] ext_addr,    // address pins
  input  wire logic        ext_rd_n,    // read strobe
  input  wire logic        ext_wr_n,    // write strobe
  input  wire logic [15:0] ext_data_o,  // data from block
  input  wire logic        ext_data_oe, // data enable
  output logic      [15:0] ext_data_i,  // data to block
  output logic             ext_ready,   // ready handshake
  input  wire logic [3:0]  wait_n,      // ready delay in clocks
  output logic      [15:0] last_w       // last written word
);
  logic [15:0] val_q;
  logic [3:0]  cnt_q;
  always_ff @(posedge clk) begin
    if (srst || (ext_rd_n && ext_wr_n)) cnt_q <= '0;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
    // data frozen while the strobe is low, so address moves do not matter
    if (ext_rd_n) val_q <= ext_addr[15:0] ^ 16'hC35A;
    if (!ext_wr_n && ext_data_oe) last_w <= ext_data_o;
  end
  assign ext_ready = (cnt_q >= wait_n);
  // inverted as soon as the strobe rises
  assign ext_data_i = ext_rd_n ? ~val_q : val_q;
endmodule

/* test_external_bus_cycle_sequencer.sv */
// self-checking bench of the external bus cycle sequencer
`timescale 1ns/1ps
`include "bus_seq_consts.svh"
module test_external_bus_cycle_sequencer;
  import bus_seq_pkg::*;
  logic        clk, srst, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic        req_valid, req_ready, req_write, done, ext_rd_n, ext_wr_n;
  logic        ext_data_oe, ext_ready;
  logic [1:0]  s_bresp, s_rresp;
  logic [3:0]  s_wstrb, ext_cs_n, wait_n;
  logic [7:0]  s_awaddr, s_araddr;
  logic [15:0] req_wdata, rd_data, ext_data_o, ext_data_i, last_w;
  logic [23:0] req_addr, ext_addr;
  logic [31:0] s_wdata, s_rdata;
  cs_t         req_cs;
  phase_e      phase;
  int          fail_count, n_checks;
  bus_cycle_sequencer bus_cycle_sequencer_inst (.*);
  ext_mem_model ext_mem_model_inst (.*);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic ck(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hang(input bit ok);
    if (!ok) begin
      ck(0, "timeout");
      finish_test;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    bit aw, wd, b;
    {aw, wd, b} = '0;
    s_awaddr <= a;
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    for (int k = 0; k < 50 && !b; k++) begin
      @(posedge clk);
      aw |= s_awvalid && s_awready;
      wd |= s_wvalid && s_wready;
      b = s_bvalid;
      r = s_bresp;
      s_awvalid <= !aw;
      s_wvalid <= !wd;
    end
    s_bready <= 0;
    @(posedge clk);
    hang(b);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    bit ar, rv;
    {ar, rv} = '0;
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'h3;
    for (int k = 0; k < 50 && !rv; k++) begin
      @(posedge clk);
      ar |= s_arvalid && s_arready;
      rv = s_rvalid;
      d = s_rdata;
      r = s_rresp;
      s_arvalid <= !ar;
    end
    s_rready <= 0;
    @(posedge clk);
    hang(rv);
  endtask
  task automatic cfg(input cs_t c, input logic [31:0] v);
    logic [1:0] r;
    axw(`TIMING_BASE + {4'h0, c, 2'b00}, v, r);
  endtask
  // one access; n counts clocks from acceptance to done
  task automatic run(input logic w, input cs_t c, input logic [15:0] d,
                     output int n);
    bit t;
    {req_valid, req_write, req_cs, req_wdata} <= {1'b1, w, c, d};
    req_addr <= {8'h5A, d};
    t = 0;
    for (n = 0; n < 300 && !t; n++) begin
      @(posedge clk);
      t = req_ready;
    end
    req_valid <= 0;
    hang(t);
    t = 0;
    for (n = 0; n < 300 && !t; n++) begin
      @(posedge clk);
      t = done;
    end
    hang(t);
  endtask
  task automatic regs_check;
    logic [31:0] d;
    logic [1:0]  r;
    axr(`TIMING_BASE, d, r);
    ck(d === `TIMING_RESET, "timing reset");
    axr(`CTRL_ADDR, d, r);
    ck(d[7:0] === `UNIT_DIV_RESET, "divider reset");
    axr(`STATUS_ADDR, d, r);
    ck(d === 32'h0 && r === 2'b00, "status reset");
    axr(8'h20, d, r);
    ck(r === 2'b10 && d === 32'h0, "unmapped read");
    axw(8'h20, 32'h1, r);
    ck(r === 2'b10, "unmapped write");
  endtask
  task automatic phase_lengths;
    logic [31:0] tv[4] = '{32'h1, 32'h18, 32'h7C0, 32'h1800};
    int          ed[4] = '{1, 3, 31, 3};
    int          b, n;
    cfg(0, 0);
    run(0, 0, 16'h1234, n);
    run(0, 0, 16'h1234, b);
    ck(rd_data === (16'h1234 ^ 16'hC35A), "read data");
    ck(ext_addr === 24'h5A1234 && ext_cs_n === 4'hF, "address pins");
    foreach (tv[i]) begin
      cfg(0, tv[i]);
      run(0, 0, 16'h1234, n);
      ck(n - b === ed[i], "phase length");
    end
  endtask
  task automatic write_window;
    int rb, b, n;
    cfg(0, 0);
    run(0, 0, 16'h0001, rb);
    run(1, 0, 16'hBEEF, b);
    ck(last_w === 16'hBEEF, "write data");
    cfg(0, 32'h20);
    run(1, 0, 16'h0F0F, n);
    ck(n - b === 1, "data setup length");
    cfg(1, 32'h6);
    run(0, 1, 16'h0002, n);
    ck(n - rb === 3, "window change");
    run(0, 1, 16'h0003, n);
    ck(n === rb, "same window");
  endtask
  task automatic ready_wait;
    int a, n;
    cfg(0, 32'h2000);
    wait_n <= 4'h3;
    run(0, 0, 16'h2222, a);
    wait_n <= 4'h6;
    run(0, 0, 16'h2222, n);
    ck(n - a === 3, "ready wait");
    ck(rd_data === (16'h2222 ^ 16'hC35A), "late read data");
    wait_n <= 4'h0;
  endtask
  task automatic unit_scale;
    int         b, n;
    logic [1:0] r;
    axw(`CTRL_ADDR, 32'h2, r);
    cfg(0, 0);
    run(0, 0, 16'h0001, b);
    cfg(0, 32'h18);
    run(0, 0, 16'h0001, n);
    ck(n - b === 6, "unit length");
  endtask
  initial begin
    srst = 1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {req_valid, req_write, req_cs, req_addr, req_wdata} = '0;
    {s_awaddr, s_araddr, s_wdata, wait_n} = '0;
    s_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    regs_check;
    phase_lengths;
    write_window;
    ready_wait;
    unit_scale;
    finish_test;
  end
endmodule
